// file: rtl/adpcm_cfg_defines.svh
// Constants for the channel configuration and time slot block
`ifndef ADPCM_CFG_DEFINES_SVH
`define ADPCM_CFG_DEFINES_SVH
`define CTRL_RESET_VALUE 8'h20
`define CHAN_SELECT_BIT 6
`define DEVICE_ADDR_MSB 5
`define SLOT_NUM_MSB 5
`define TAG_COMMAND 2'h0
`define TAG_CONTROL 2'h1
`define TAG_IN_SLOT 2'h2
`define TAG_OUT_SLOT 2'h3
`define BYTE_LAST_BIT 3'h7
`define BYTES_MAX 3'h4
`define ALG_RESET_CYCLES 8'h10
`define UPDATE_HOLD_CYCLES 3'h4
`define CLOCK_MHZ 100
`define POWERUP_TIME_MS 800
`define FRAME_BITS_MU_LAW 9'h100
`define FRAME_BITS_A_LAW 9'h100
`define SLOT_COUNT_IDLE 9'h1FF
`define FIFO_DEPTH 16
`define CFG_WORD_WIDTH 10
`endif

// file: rtl/adpcm_cfg_pkg.sv
// Types shared by the channel configuration block and its testbench
package adpcm_cfg_pkg;
  typedef struct packed {
    logic rate_select_bit_zero;
    logic rate_select_bit_one;
    logic idle_power_down;
    logic algorithm_state_reset;
    logic pass_through;
    logic format_mu_law;
    logic rate_select_bit_two;
    logic coding_direction;
  } ctrl_type;

  typedef struct packed {
    logic [1:0] tag;
    logic [7:0] data;
  } cfg_word_type;
endpackage

// file: rtl/cfg_word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module cfg_word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
)(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_type;

  fifo_state_type st_q;
  fifo_state_type st_d;
  logic push;
  logic pop;

  assign in_ready_out = (st_q.count != (AW+1)'(DEPTH));
  assign out_valid_out = (st_q.count != '0);
  assign out_data_out = st_q.mem[st_q.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr_ptr] = in_data_in;
      st_d.wr_ptr = (st_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(st_q.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(st_q.rd_ptr + 1'b1);
    end
    st_d.count = (AW+1)'(st_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    if (reset_in)
    begin
      st_d.wr_ptr = '0;
      st_d.rd_ptr = '0;
      st_d.count = '0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    st_q <= st_d;
  end

  fifo_bound_a: assert property (@(posedge clock_in) disable iff (reset_in)
    st_q.count <= (AW+1)'(DEPTH)) else $error("FIFO count beyond depth");
endmodule

// file: rtl/adpcm_channel_config_and_slots.sv
// Channel configuration registers, serial command port and TDM slot timing
`timescale 1ns/10ps
`include "adpcm_cfg_defines.svh"

// Function
// R01: Host writes zero into reserved bits
// R02: Command bit 6 picks X (1) or Y
// R03: Command bits 5..0 carry device address
// R04: Idle bit disables channel, tri-states output
// R05: Algorithm reset bit restarts channel state
// R06: Pass-through bit skips compression and expansion
// R07: Format bit: 0 A-law, 1 mu-law
// R08: Direction bit: 0 expand, 1 compress
// R09: Rate bits 1,6,7: 000/111/101 select rate
// R10: Input slot number in bits 5..0
// R11: Output slot number in bits 5..0
// R12: Slot counters; PCM 8-bit, ADPCM 4-bit
// R13: Slot count from direction and format
// R14: Rate never changes slot organisation
// R15: Slots count from first rise after sync
// R16: Strap low: port off, registers cleared, pins
// R17: Strap mode fixes all slots at zero
// R18: Strap mode maps pins to direction/format/idle
// R19: Rate pins: low/high; late rise gives 24k
// R20: Serial clock held low in strap mode
// R21: Powered up within 800 ms after idle
// R22: Two or four bytes, address must match
// R23: LSB first, sampled on serial clock rise
// R24: Device clears algorithm reset bit itself
// R25: Reset clears controls, sets idle bits
// R26: Two-byte write leaves slot registers alone
module adpcm_channel_config_and_slots
  import adpcm_cfg_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = `POWERUP_TIME_MS * `CLOCK_MHZ * 1000,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
)(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic serial_clock_in,
  input wire logic serial_config_input_in,
  input wire logic chip_select_n_in,
  input wire logic [5:0] address_pin_in,
  input wire logic port_select_strap_in,
  input wire logic x_side_bit_clock_in,
  input wire logic x_side_frame_sync_in,
  input wire logic x_side_serial_in,
  input wire logic y_side_bit_clock_in,
  input wire logic y_side_frame_sync_in,
  input wire logic y_side_serial_in,
  input wire logic [1:0][7:0] coded_word_in,
  output logic x_side_serial_out,
  output logic x_side_serial_oe_out,
  output logic y_side_serial_out,
  output logic y_side_serial_oe_out,
  output ctrl_type [1:0] channel_control_out,
  output logic [1:0][5:0] input_slot_out,
  output logic [1:0][5:0] output_slot_out,
  output logic [1:0][7:0] captured_word_out,
  output logic [1:0] captured_valid_out,
  output logic [1:0] channel_ready_out
);
  // ---------------------------------------------------------------
  // Pin sampling layout
  // ---------------------------------------------------------------
  localparam int SYNC_W = 16;
  localparam int S_SCLK = 0;
  localparam int S_SDI = 1;
  localparam int S_CSN = 2;
  localparam int S_STRAP = 3;
  localparam int S_CH0 = 4;
  localparam int S_ADDR = 10;
  localparam int ALG_BOUND = 20;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] prev;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [2:0] byte_idx;
    logic match;
    logic target;
    ctrl_type [1:0] ctrl;
    logic [1:0][5:0] in_slot;
    logic [1:0][5:0] out_slot;
    logic [2:0] hold_cnt;
    logic [1:0][7:0] alg_cnt;
    logic [1:0][31:0] pwr_cnt;
    logic [1:0] ready;
    logic rate_low_at_reset;
    logic [1:0] fs_pend;
    logic [1:0][8:0] cnt;
    logic [1:0][7:0] in_word;
    logic [1:0][7:0] cap_word;
    logic [1:0] cap_valid;
    logic [1:0] out_bit;
    logic [1:0] out_en;
  } state_type;

  state_type st_q;
  state_type st_d;
  ctrl_type [1:0] eff;
  logic [SYNC_W-1:0] sync_raw;
  logic [5:0] addr;
  logic strap_mode;
  logic sclk_rise;
  logic push_valid;
  logic push_ready;
  cfg_word_type push_word;
  logic pop_valid;
  logic pop_ready;
  cfg_word_type pop_word;
  logic pop_fire;
  logic rate_hi;

  function automatic logic slot_hit(input logic [8:0] c, input logic w8,
                                    input logic [5:0] slot, input logic [8:0] frame_bits);
    logic [6:0] num;
    num = w8 ? {1'b0, c[8:3]} : c[8:2];
    return (c < frame_bits) && (num == {1'b0, slot});
  endfunction

  function automatic logic [2:0] slot_pos(input logic [8:0] c, input logic w8);
    return w8 ? c[2:0] : {1'b0, c[1:0]};
  endfunction

  assign sync_raw = {address_pin_in, x_side_serial_in, x_side_frame_sync_in,
                     x_side_bit_clock_in, y_side_serial_in, y_side_frame_sync_in,
                     y_side_bit_clock_in, port_select_strap_in, chip_select_n_in,
                     serial_config_input_in, serial_clock_in};
  assign addr = st_q.sync2[S_ADDR +: 6];
  assign strap_mode = !st_q.sync2[S_STRAP];
  assign sclk_rise = st_q.sync2[S_SCLK] && !st_q.prev[S_SCLK];
  assign rate_hi = addr[1] && addr[4];

  // ---------------------------------------------------------------
  // Effective channel settings
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      eff[ch] = st_q.ctrl[ch];
      if (strap_mode)
      begin
        eff[ch] = '0;
        // R18: pin mapping in strap mode
        eff[ch].coding_direction = (ch == 1) ? addr[0] : addr[3];
        eff[ch].format_mu_law = (ch == 1) ? addr[2] : addr[5];
        eff[ch].idle_power_down = (ch == 1) ? st_q.sync2[S_CSN] : st_q.sync2[S_SDI];
        // R19: 24k only when pins rose after reset
        eff[ch].rate_select_bit_two = rate_hi;
        eff[ch].rate_select_bit_zero = rate_hi;
        eff[ch].rate_select_bit_one = rate_hi && st_q.rate_low_at_reset;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command byte buffer
  // ---------------------------------------------------------------
  // R23: shift in LSB first on serial clock rise
  assign push_valid = sclk_rise && !st_q.sync2[S_CSN] && !strap_mode &&
                      st_q.bit_cnt == `BYTE_LAST_BIT && st_q.byte_idx != `BYTES_MAX;
  assign push_word = '{tag: st_q.byte_idx[1:0], data: {st_q.sync2[S_SDI], st_q.shift[7:1]}};
  // Draining pauses while outputs are tri-stated for an update
  assign pop_ready = (st_q.hold_cnt == '0);
  assign pop_fire = pop_valid && pop_ready;

  cfg_word_fifo #(
    .WIDTH(`CFG_WORD_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) cmd_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in || strap_mode),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_word),
    .out_valid_out(pop_valid),
    .out_ready_in(pop_ready),
    .out_data_out(pop_word)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic w8;
    logic [8:0] frame_bits;
    logic [8:0] ncnt;
    logic [2:0] pos;
    logic [7:0] src;
    logic rise;
    logic fall;
    logic din;
    st_d = st_q;
    w8 = 1'b0;
    frame_bits = '0;
    ncnt = '0;
    pos = '0;
    src = '0;
    rise = 1'b0;
    fall = 1'b0;
    din = 1'b0;
    st_d.sync1 = sync_raw;
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;
    st_d.cap_valid = '0;
    if (reset_in)
    begin
      st_d.bit_cnt = '0;
      st_d.byte_idx = '0;
      st_d.match = 1'b0;
      st_d.target = 1'b0;
      // R25: idle set, every other control bit clear
      st_d.ctrl = {2{ctrl_type'(`CTRL_RESET_VALUE)}};
      st_d.in_slot = '0;
      st_d.out_slot = '0;
      st_d.hold_cnt = '0;
      st_d.alg_cnt = '0;
      st_d.pwr_cnt = '0;
      st_d.ready = '0;
      st_d.fs_pend = '0;
      st_d.cnt = {2{`SLOT_COUNT_IDLE}};
      st_d.in_word = '0;
      st_d.cap_word = '0;
      st_d.out_bit = '0;
      st_d.out_en = '0;
      // Rate pins seen low during reset allow the late-rise 24k choice
      st_d.rate_low_at_reset = !(addr[1] || addr[4]);
    end
    else
    begin
      // Serial shifter; a full buffer aborts the rest of the transfer
      if (strap_mode || st_q.sync2[S_CSN])
      begin
        st_d.bit_cnt = '0;
        st_d.byte_idx = '0;
      end
      else if (sclk_rise)
      begin
        st_d.shift = {st_q.sync2[S_SDI], st_q.shift[7:1]};
        st_d.bit_cnt = 3'(st_q.bit_cnt + 1'b1);
        if (push_valid)
        begin
          st_d.byte_idx = push_ready ? 3'(st_q.byte_idx + 1'b1) : `BYTES_MAX;
        end
      end
      if (st_q.hold_cnt != '0)
      begin
        st_d.hold_cnt = 3'(st_q.hold_cnt - 1'b1);
      end
      // R24: algorithm reset bit self-clears
      for (int ch = 0; ch < 2; ch++)
      begin
        if (st_q.alg_cnt[ch] != '0)
        begin
          st_d.alg_cnt[ch] = 8'(st_q.alg_cnt[ch] - 1'b1);
          if (st_q.alg_cnt[ch] == 8'h01)
          begin
            st_d.ctrl[ch].algorithm_state_reset = 1'b0;
          end
        end
      end
      if (pop_fire)
      begin
        case (pop_word.tag)
          `TAG_COMMAND:
          begin
            // R03: six-bit address must match the pins
            st_d.match = (pop_word.data[`DEVICE_ADDR_MSB:0] == addr);
            // R02: channel select bit
            st_d.target = pop_word.data[`CHAN_SELECT_BIT];
          end
          `TAG_CONTROL:
          begin
            // R22: bytes after a mismatched address are ignored
            if (st_q.match)
            begin
              // R26: only the control register changes here
              st_d.ctrl[st_q.target] = ctrl_type'(pop_word.data);
              st_d.hold_cnt = `UPDATE_HOLD_CYCLES;
              // R05: a written reset bit restarts the channel's state
              if (pop_word.data[4])
              begin
                st_d.alg_cnt[st_q.target] = `ALG_RESET_CYCLES;
              end
            end
          end
          `TAG_IN_SLOT:
          begin
            // R10: input slot number
            if (st_q.match)
            begin
              st_d.in_slot[st_q.target] = pop_word.data[`SLOT_NUM_MSB:0];
              st_d.hold_cnt = `UPDATE_HOLD_CYCLES;
            end
          end
          default:
          begin
            // R11: output slot number
            if (st_q.match)
            begin
              st_d.out_slot[st_q.target] = pop_word.data[`SLOT_NUM_MSB:0];
              st_d.hold_cnt = `UPDATE_HOLD_CYCLES;
            end
          end
        endcase
      end
      // R16: strap mode clears all register bits
      if (strap_mode)
      begin
        st_d.ctrl = '0;
        st_d.alg_cnt = '0;
        st_d.match = 1'b0;
        // R17: slots fixed at zero
        st_d.in_slot = '0;
        st_d.out_slot = '0;
      end
      for (int ch = 0; ch < 2; ch++)
      begin
        // R21: power-up timer after leaving idle
        if (eff[ch].idle_power_down)
        begin
          st_d.pwr_cnt[ch] = '0;
          st_d.ready[ch] = 1'b0;
        end
        else if (st_q.pwr_cnt[ch] == POWERUP_CYCLES - 1)
        begin
          // Counter parks one below the limit once ready
          st_d.ready[ch] = 1'b1;
        end
        else
        begin
          st_d.pwr_cnt[ch] = st_q.pwr_cnt[ch] + 1;
        end
        rise = st_q.sync2[S_CH0 + 3*ch] && !st_q.prev[S_CH0 + 3*ch];
        fall = !st_q.sync2[S_CH0 + 3*ch] && st_q.prev[S_CH0 + 3*ch];
        din = st_q.sync2[S_CH0 + 3*ch + 2];
        // R12: compress means 8-bit PCM in and 4-bit ADPCM out
        // R14: rate bits take no part in slot layout
        w8 = eff[ch].coding_direction;
        // R13: frame length from format
        frame_bits = eff[ch].format_mu_law ? `FRAME_BITS_MU_LAW : `FRAME_BITS_A_LAW;
        pos = slot_pos(st_q.cnt[ch], w8);
        if (fall)
        begin
          if (st_q.sync2[S_CH0 + 3*ch + 1])
          begin
            st_d.fs_pend[ch] = 1'b1;
          end
          if (!eff[ch].idle_power_down &&
              slot_hit(st_q.cnt[ch], w8, st_q.in_slot[ch], frame_bits))
          begin
            st_d.in_word[ch] = {st_q.in_word[ch][6:0], din};
            if (pos == (w8 ? 3'h7 : 3'h3))
            begin
              st_d.cap_word[ch] = {st_q.in_word[ch][6:0], din};
              st_d.cap_valid[ch] = 1'b1;
            end
          end
        end
        if (rise)
        begin
          // R15: first rise after frame sync is bit 0 of slot 0
          ncnt = st_q.fs_pend[ch] ? 9'h000 :
                 (st_q.cnt[ch] == `SLOT_COUNT_IDLE) ? `SLOT_COUNT_IDLE :
                 9'(st_q.cnt[ch] + 1'b1);
          st_d.cnt[ch] = ncnt;
          st_d.fs_pend[ch] = 1'b0;
          pos = slot_pos(ncnt, !w8);
          // R06: pass-through sends the captured word in place of the coded word, only its low four bits when compressing
          src = eff[ch].pass_through ? st_q.cap_word[ch] : coded_word_in[ch];
          st_d.out_bit[ch] = !w8 ? src[~pos] : src[{1'b0, ~pos[1:0]}];
          st_d.out_en[ch] = slot_hit(ncnt, !w8, st_q.out_slot[ch], frame_bits);
        end
        // R04: idle or register update tri-states output
        if (eff[ch].idle_power_down || st_q.hold_cnt != '0)
        begin
          st_d.out_en[ch] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign y_side_serial_out = st_q.out_bit[0];
  assign x_side_serial_out = st_q.out_bit[1];
  assign y_side_serial_oe_out = st_q.out_en[0] && !eff[0].idle_power_down && pop_ready;
  assign x_side_serial_oe_out = st_q.out_en[1] && !eff[1].idle_power_down && pop_ready;
  // R07: format bit and R08: direction bit reach the engine here
  // R09: rate bits pass through unchanged
  assign channel_control_out = eff;
  assign input_slot_out = st_q.in_slot;
  assign output_slot_out = st_q.out_slot;
  assign captured_word_out = st_q.cap_word;
  assign captured_valid_out = st_q.cap_valid;
  assign channel_ready_out = st_q.ready;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  reset_idle_a: assert property (disable iff (1'b0) // R25
    reset_in ##1 !reset_in |-> st_q.ctrl[0] == `CTRL_RESET_VALUE &&
    st_q.ctrl[1] == `CTRL_RESET_VALUE) else $error("Reset control value wrong");
  strap_clear_a: assert property (strap_mode ##1 strap_mode |-> // R16
    st_q.ctrl == '0 && st_q.in_slot == '0 && st_q.out_slot == '0)
    else $error("Strap mode left register bits set");
  strap_map_a: assert property (strap_mode |-> // R18
    eff[1].coding_direction == addr[0] && eff[0].format_mu_law == addr[5] &&
    eff[1].idle_power_down == st_q.sync2[S_CSN]) else $error("Strap pin map wrong");
  strap_rate_a: assert property (strap_mode && rate_hi && !st_q.rate_low_at_reset |-> // R19
    {eff[1].rate_select_bit_two, eff[1].rate_select_bit_one,
     eff[1].rate_select_bit_zero} == 3'b101) else $error("Strap rate not 16k");
  alg_clear_a: assert property ($rose(st_q.ctrl[1].algorithm_state_reset) && !strap_mode // R24
    |-> ##[1:ALG_BOUND] !st_q.ctrl[1].algorithm_state_reset) else $error("Alg reset stuck");
  idle_tristate_a: assert property (eff[1].idle_power_down |-> !x_side_serial_oe_out) // R04
    else $error("Idle channel drives output");
  chan_select_a: assert property (pop_fire && pop_word.tag == `TAG_COMMAND |=> // R02
    st_q.target == $past(pop_word.data[`CHAN_SELECT_BIT])) else $error("Wrong channel");
  slot_keep_a: assert property (pop_fire && pop_word.tag == `TAG_CONTROL && !strap_mode // R26
    |=> st_q.in_slot == $past(st_q.in_slot)) else $error("Control write moved slot");
  lsb_first_a: assert property (sclk_rise && !st_q.sync2[S_CSN] && !strap_mode |=> // R23
    st_q.shift[7] == $past(st_q.sync2[S_SDI])) else $error("Serial bit order wrong");
  frame_start_a: assert property (st_q.sync2[S_CH0 + 3] && !st_q.prev[S_CH0 + 3] && // R15
    st_q.fs_pend[1] |=> st_q.cnt[1] == 9'h000) else $error("Slot count not restarted");
  out_slot_a: assert property (x_side_serial_oe_out |-> // R12
    slot_hit(st_q.cnt[1], !eff[1].coding_direction, st_q.out_slot[1],
    eff[1].format_mu_law ? `FRAME_BITS_MU_LAW : `FRAME_BITS_A_LAW))
    else $error("Output outside its slot");
  powerup_a: assert property (st_q.pwr_cnt[1] < POWERUP_CYCLES) // R21
    else $error("Power-up exceeded its time");

  four_byte_c: cover property (pop_fire && pop_word.tag == `TAG_OUT_SLOT && st_q.match);
  strap_c: cover property (strap_mode && !eff[1].idle_power_down);
  x_drive_c: cover property (x_side_serial_oe_out);
endmodule

// file: testbench/host_ctrl_model.sv
// Serial configuration host that shifts command bytes into the block
`timescale 1ns/10ps
module host_ctrl_model (
  input wire logic clock_in,
  output logic sclk_out,
  output logic sdi_out,
  output logic cs_n_out
);
  initial
  begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic send(input logic [31:0] bytes, input int n);
    for (int i = 0; i < n * 8; i++)
    begin
      repeat (10) @(negedge clock_in);
      cs_n_out = 1'b0;
      sdi_out = bytes[i];
      sclk_out = 1'b0;
      repeat (10) @(negedge clock_in);
      sclk_out = 1'b1;
    end
    repeat (10) @(negedge clock_in);
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    // Released line shows a changed value, never the last bit
    sdi_out = ~sdi_out;
  endtask
  // serial clock low in strap mode
  task automatic strap(input logic sdi_v, input logic cs_v);
    sclk_out = 1'b0;
    sdi_out = sdi_v;
    cs_n_out = cs_v;
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the channel configuration and slot timing block
`timescale 1ns/10ps
module tb_top
  import adpcm_cfg_pkg::*;
;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic strap = 1'b1;
  logic [5:0] addr = 6'h15;
  logic [1:0] bclk = 2'b01;
  logic fs_x = 1'b0;
  logic sin_x = 1'b0;
  logic [1:0][7:0] coded = '0;
  logic sclk, serial_config_input, cs_n;
  logic [1:0] sout, soe, capv, rdy;
  ctrl_type [1:0] ctrl;
  logic [1:0][5:0] islot, oslot;
  logic [1:0][7:0] cap;
  logic [9:0] exp_q[$];
  logic alg_seen = 1'b0;
  logic [7:0] r;
  logic [5:0] rs1, rs2;
  int num_errors = 0;
  int num_checks = 0;

  adpcm_channel_config_and_slots #(.POWERUP_CYCLES(50), .FIFO_DEPTH(16))
    i_adpcm_channel_config_and_slots (
    .clock_in(clock_in), .reset_in(reset_in), .serial_clock_in(sclk),
    .serial_config_input_in(serial_config_input), .chip_select_n_in(cs_n), .address_pin_in(addr),
    .port_select_strap_in(strap), .x_side_bit_clock_in(bclk[1]),
    .x_side_frame_sync_in(fs_x), .x_side_serial_in(sin_x), .y_side_bit_clock_in(bclk[0]),
    .y_side_frame_sync_in(1'b0), .y_side_serial_in(1'b0), .coded_word_in(coded),
    .x_side_serial_out(sout[1]), .x_side_serial_oe_out(soe[1]), .y_side_serial_out(sout[0]),
    .y_side_serial_oe_out(soe[0]), .channel_control_out(ctrl), .input_slot_out(islot),
    .output_slot_out(oslot), .captured_word_out(cap), .captured_valid_out(capv),
    .channel_ready_out(rdy));
  host_ctrl_model i_host_ctrl_model (.clock_in(clock_in), .sclk_out(sclk), .sdi_out(serial_config_input),
    .cs_n_out(cs_n));

  always #5 clock_in = ~clock_in;
  // Two link clocks of 125 ns, half a period apart, unrelated to the system clock
  always #62.5 bclk = ~bclk;

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clock_in);
    reset_in = 1'b1;
    repeat (20) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (5) @(negedge clock_in);
  endtask

  task automatic wr(input logic [7:0] acb, input logic [7:0] cr, input logic [5:0] is,
    input logic [5:0] os, input int cnt);
    i_host_ctrl_model.send({2'b00, os, 2'b00, is, cr, acb}, cnt);
    repeat (30) @(negedge clock_in);
  endtask

  task automatic frame(input logic [7:0] b);
    logic [3:0] got;
    got = '0;
    exp_q.push_back({2'b00, b});
    @(posedge bclk[1]);
    @(negedge clock_in);
    fs_x = 1'b1;
    @(posedge bclk[1]);
    @(negedge clock_in);
    fs_x = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      sin_x = b[i];
      @(negedge bclk[1]);
      if (i == 7)
        check({9'h0, soe[1]}, 10'h001);
      if (i > 3)
        got = {got[2:0], sout[1]};
      @(posedge bclk[1]);
      @(negedge clock_in);
    end
    sin_x = ~sin_x;
    check({6'h0, got}, {6'h0, coded[1][3:0]});
    repeat (20) @(negedge clock_in);
    check(10'(exp_q.size()), 10'h000);
  endtask

  // ---------------------------------------------
  // Capture watcher: takes the oldest note per word
  // ---------------------------------------------
  always @(negedge clock_in)
  begin
    if (ctrl[1].algorithm_state_reset === 1'b1)
      alg_seen <= 1'b1;
    if (capv[1] === 1'b1)
      check({2'b00, cap[1]}, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    if (capv[0] === 1'b1)
      check(10'h001, 10'h000);
  end

  initial
  begin
    void'($urandom(38));
    coded = 16'($urandom);
    do_reset();
    for (int c = 0; c < 2; c++)
    begin
      check({2'b00, ctrl[c]}, 10'h020);
      check({4'h0, islot[c]}, 10'h000);
      check({4'h0, oslot[c]}, 10'h000);
    end
    $display("test reset done");
    r = 8'($urandom) & 8'hEF;
    rs1 = 6'($urandom);
    rs2 = 6'($urandom);
    wr({2'b01, addr}, r, rs1, rs2, 4);
    check({2'b00, ctrl[1]}, {2'b00, r});
    check({4'h0, islot[1]}, {4'h0, rs1});
    check({4'h0, oslot[1]}, {4'h0, rs2});
    check({2'b00, ctrl[0]}, 10'h020);
    r = 8'($urandom) & 8'hEF | 8'h20;
    wr({2'b00, addr}, r, 6'h3F, 6'h3F, 2);
    check({2'b00, ctrl[0]}, {2'b00, r});
    check({4'h0, islot[0]}, 10'h000);
    check({4'h0, oslot[0]}, 10'h000);
    wr({2'b01, addr ^ 6'h20}, 8'h00, 6'h01, 6'h01, 4);
    check({4'h0, islot[1]}, {4'h0, rs1});
    $display("test serial writes done");
    wr({2'b01, addr}, 8'h15, 6'h00, 6'h00, 4);
    check({2'b00, ctrl[1]}, 10'h005);
    check({9'h0, alg_seen}, 10'h001);
    frame(8'($urandom));
    check({8'h0, rdy}, 10'h002);
    $display("test slot timing done");
    for (int k = 0; k < 3; k++)
    begin
      strap = 1'b0;
      addr = (k == 1) ? 6'h3F : 6'h2D;
      i_host_ctrl_model.strap(1'b1, 1'b0);
      do_reset();
      if (k == 2)
      begin
        // rate pins rise only after the 3.1 us wait
        repeat (310) @(negedge clock_in);
        addr = 6'h3F;
        repeat (5) @(negedge clock_in);
      end
      check({2'b00, ctrl[1]}, k == 0 ? 10'h005 : k == 1 ? 10'h087 : 10'h0C7);
      check({2'b00, ctrl[0]}, k == 0 ? 10'h025 : k == 1 ? 10'h0A7 : 10'h0E7);
      check({9'h0, |{islot, oslot}}, 10'h000);
    end
    $display("test strap mode done");
    strap = 1'b1;
    i_host_ctrl_model.strap(1'b0, 1'b1);
    do_reset();
    // Back-to-back writes pass through the command buffer one byte at a time
    i_host_ctrl_model.send({2'b00, 6'h2A, 2'b00, 6'h15, 8'h20, 2'b00, addr}, 4);
    wr({2'b01, addr}, 8'h24, 6'h00, 6'h00, 2);
    check({4'h0, islot[0]}, 10'h015);
    check({4'h0, oslot[0]}, 10'h02A);
    check({2'b00, ctrl[0]}, 10'h020);
    check({2'b00, ctrl[1]}, 10'h024);
    check({4'h0, islot[1]}, 10'h000);
    $display("test buffer done");
    report_and_stop();
  end

  // Watchdog: a hung scenario counts as a mismatch
  initial
  begin
    repeat (60000) @(negedge clock_in);
    num_errors++;
    $display("[FAIL] %0t run timed out", $time);
    report_and_stop();
  end
endmodule
